// file: logic/fpp_pkg.sv
// Package for the fault pin propagation block: command code, field layout, timing
package fpp_pkg;

  localparam int          FPP_PAGES         = 2;
  localparam logic [7:0]  FPP_CMD_PROPAGATE = 8'hD2;
  localparam logic [15:0] FPP_PROP_RESET    = 16'h6993;
  // Writable bits; reserved 12,10,9,6,5,3 read back as zero
  // Bit 0 stays writable so the default word can be stored and restored
  localparam logic [15:0] FPP_PROP_MASK     = 16'hE997;

  localparam int FPP_BIT_DECAY   = 15;
  localparam int FPP_BIT_SHORT   = 14;
  localparam int FPP_BIT_TON_MAX = 13;
  localparam int FPP_BIT_INT_OT  = 11;
  localparam int FPP_BIT_UT      = 8;
  localparam int FPP_BIT_OT      = 7;
  localparam int FPP_BIT_VIN_OV  = 4;
  localparam int FPP_BIT_IOUT_OC = 2;
  localparam int FPP_BIT_VOUT_UV = 1;

  localparam int FPP_CLK_HZ       = 50_000_000;
  localparam int FPP_SHORT_HOLD_MS = 120;
  localparam int FPP_SHORT_HOLD_CYC = FPP_CLK_HZ / 1000 * FPP_SHORT_HOLD_MS;

  // Per-page fault flags, one per fault propagation bit (seven), used for detected faults and for response settings
  typedef struct packed {
    logic ton_max;
    logic int_ot;
    logic ut;
    logic ot;
    logic vin_ov;
    logic iout_oc;
    logic vout_uv;
  } fpp_faults_t;

  // Per-page sequencing status
  typedef struct packed {
    logic decay_wait;
    logic short_cycle;
    logic seq_off_done;
  } fpp_seq_t;

  typedef enum logic [1:0] {
    FPP_SC_IDLE = 2'b00,
    FPP_SC_WAIT = 2'b01,
    FPP_SC_HOLD = 2'b10
  } fpp_sc_state_t;

endpackage : fpp_pkg

// file: logic/fpp_short_cycle.sv
// Short command-cycle pin hold timer for one page
module fpp_short_cycle
  import fpp_pkg::*;
#(
  parameter int HOLD_CYC = FPP_SHORT_HOLD_CYC
) (
  input  wire logic clk_i,          // System clock
  input  wire logic reset_i,        // Synchronous reset
  input  wire logic enable_i,       // Propagation bit 14
  input  wire logic short_cycle_i,  // Off then on before sequenced off
  input  wire logic seq_off_done_i, // Off sequence completed
  output logic      pull_o          // Request to pull pin low
);
  localparam int CW = $clog2(HOLD_CYC + 1);

  fpp_sc_state_t   state_q, state_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic            pull_q, pull_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      FPP_SC_IDLE:
      begin
        cnt_d = '0;
        if (enable_i && short_cycle_i)
          state_d = FPP_SC_WAIT;
      end
      FPP_SC_WAIT:
      begin
        if (seq_off_done_i)
          state_d = FPP_SC_HOLD;
      end
      FPP_SC_HOLD:
      begin
        // Release 120 ms after sequence off
        if (cnt_q == CW'(HOLD_CYC - 1))
          state_d = FPP_SC_IDLE;
        else
          cnt_d = cnt_q + CW'(1);
      end
      default:
        state_d = FPP_SC_IDLE;
    endcase
    pull_d = (state_d != FPP_SC_IDLE);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= FPP_SC_IDLE;
      cnt_q   <= '0;
      pull_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pull_q  <= pull_d;
    end
  end

  assign pull_o = pull_q;

endmodule : fpp_short_cycle

// file: logic/fpp_fault_propagate.sv
// Paged fault pin propagation configuration and fault pin drivers
// Functional notes
// - Paged 16-bit RW word at command 0xD2, default 0x6993.
// - Faults reach pins only when their response setting reacts.
// - Multiphase mode: re-enable waits until output decays to 12.5 percent.
// - During decay wait, pin held low only if bit 15 set.
// - Bit 14: short off-on cycle pulls pin, releases 120 ms after off.
// - Bit 13: turn-on-time-max fault pulls its own page's pin.
// - Bit 11: internal die overtemperature pulls that page's pin.
// - Bit 8: undertemperature fault pulls its page's pin.
// - Common events drive both pins, channel events only their own.
// - Bit 7: overtemperature limit fault pulls its page's pin.
// - Bit 4: input overvoltage fault pulls both pins.
// - Bit 2: output overcurrent fault pulls its page's pin.
// - Bit 1: output undervoltage fault pulls its page's pin.
module fpp_fault_propagate
  import fpp_pkg::*;
#(
  parameter int HOLD_CYC = FPP_SHORT_HOLD_CYC
) (
  input  wire logic                     clk_i,          // System clock
  input  wire logic                     reset_i,        // Synchronous reset
  input  wire logic                     cmd_wr_i,       // Command write strobe
  input  wire logic                     cmd_rd_i,       // Command read strobe
  input  wire logic [7:0]               cmd_code_i,     // Command code
  input  wire logic                     cmd_page_i,     // Selected page
  input  wire logic [15:0]              cmd_wdata_i,    // Write word
  input  wire logic                     nvm_load_i,     // Load stored words
  input  wire logic [FPP_PAGES-1:0][15:0] nvm_word_i,   // Stored words
  input  wire logic [FPP_PAGES-1:0]     multiphase_i,   // Chan config bit 0 clear
  input  wire logic [FPP_PAGES-1:0]     run_req_i,      // Channel commanded on
  input  wire logic [FPP_PAGES-1:0]     decayed_i,      // Output below 12.5 pct
  input  wire fpp_pkg::fpp_faults_t [FPP_PAGES-1:0] fault_i,      // Detected faults
  input  wire fpp_pkg::fpp_faults_t [FPP_PAGES-1:0] respond_i,    // Response reacts
  input  wire fpp_pkg::fpp_seq_t [FPP_PAGES-1:0]    seq_i,        // Sequencing status
  output logic [15:0]                   cmd_rdata_o,    // Read word
  output logic                          cmd_hit_o,      // Command recognised
  output logic [FPP_PAGES-1:0]          restart_ok_o,   // Channel may restart
  output logic                          fault_line_zero_n_o, // Page 0 pin, low = fault
  output logic                          fault_line_zero_oe_n_o, // Low while driving
  output logic                          fault_line_one_n_o,  // Page 1 pin, low = fault
  output logic                          fault_line_one_oe_n_o   // Low while driving
);
  import fpp_pkg::*;

  logic [FPP_PAGES-1:0][15:0] prop_q, prop_d;
  logic [15:0]                rdata_q, rdata_d;
  logic                       hit_q, hit_d;
  logic [FPP_PAGES-1:0]       restart_q, restart_d;
  logic [FPP_PAGES-1:0]       pin_q, pin_d;
  logic [FPP_PAGES-1:0]       short_pull;
  logic                       common_pull;

  // Register file
  always_comb
  begin
    prop_d  = prop_q;
    rdata_d = rdata_q;
    hit_d   = 1'b0;
    if (nvm_load_i)
    begin
      for (int p = 0; p < FPP_PAGES; p++)
        prop_d[p] = nvm_word_i[p] & FPP_PROP_MASK;
    end
    else if (cmd_code_i == FPP_CMD_PROPAGATE)
    begin
      hit_d = cmd_wr_i | cmd_rd_i;
      if (cmd_wr_i)
        prop_d[cmd_page_i] = cmd_wdata_i & FPP_PROP_MASK;
      if (cmd_rd_i)
        rdata_d = prop_q[cmd_page_i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int p = 0; p < FPP_PAGES; p++)
        prop_q[p] <= FPP_PROP_RESET;
      rdata_q <= '0;
      hit_q   <= 1'b0;
    end
    else
    begin
      prop_q  <= prop_d;
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // Input overvoltage is shared by both channels
  always_comb
  begin
    common_pull = 1'b0;
    for (int p = 0; p < FPP_PAGES; p++)
      common_pull = common_pull | (prop_q[p][FPP_BIT_VIN_OV] & fault_i[p].vin_ov
                                   & respond_i[p].vin_ov);
  end

  genvar g;
  generate
    for (g = 0; g < FPP_PAGES; g++)
    begin : g_page
      fpp_short_cycle #(
        .HOLD_CYC (HOLD_CYC)
      ) u_short (
        .clk_i          (clk_i),
        .reset_i        (reset_i),
        .enable_i       (prop_q[g][FPP_BIT_SHORT]),
        .short_cycle_i  (seq_i[g].short_cycle),
        .seq_off_done_i (seq_i[g].seq_off_done),
        .pull_o         (short_pull[g])
      );

      logic waiting;
      logic chan_pull;

      always_comb
      begin
        // Restart withheld until decayed in multiphase mode
        waiting = multiphase_i[g] & run_req_i[g] & seq_i[g].decay_wait
                  & ~decayed_i[g];
        restart_d[g] = run_req_i[g] & ~waiting;
        chan_pull =
            (prop_q[g][FPP_BIT_DECAY]   & waiting)
          | short_pull[g]
          | (prop_q[g][FPP_BIT_TON_MAX] & fault_i[g].ton_max & respond_i[g].ton_max)
          | (prop_q[g][FPP_BIT_INT_OT]  & fault_i[g].int_ot  & respond_i[g].int_ot)
          | (prop_q[g][FPP_BIT_UT]      & fault_i[g].ut      & respond_i[g].ut)
          | (prop_q[g][FPP_BIT_OT]      & fault_i[g].ot      & respond_i[g].ot)
          | (prop_q[g][FPP_BIT_IOUT_OC] & fault_i[g].iout_oc & respond_i[g].iout_oc)
          | (prop_q[g][FPP_BIT_VOUT_UV] & fault_i[g].vout_uv & respond_i[g].vout_uv);
        pin_d[g] = chan_pull | common_pull;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      restart_q <= '0;
      pin_q     <= '0;
    end
    else
    begin
      restart_q <= restart_d;
      pin_q     <= pin_d;
    end
  end

  // Open drain: data held low, enable active only while pulling
  assign cmd_rdata_o            = rdata_q;
  assign cmd_hit_o              = hit_q;
  assign restart_ok_o           = restart_q;
  assign fault_line_zero_n_o    = 1'b0;
  assign fault_line_zero_oe_n_o = ~pin_q[0];
  assign fault_line_one_n_o     = 1'b0;
  assign fault_line_one_oe_n_o  = ~pin_q[1];

endmodule : fpp_fault_propagate

// file: bench/fpp_line_model.sv
// Open-drain fault line pair with pull-ups, as seen from the host side
module fpp_line_model (
  input  wire logic zero_n_i,    // Pin 0 data
  input  wire logic zero_oe_n_i, // Pin 0 enable, low drives
  input  wire logic one_n_i,     // Pin 1 data
  input  wire logic one_oe_n_i,  // Pin 1 enable, low drives
  output logic      zero_o,      // Pin 0 level
  output logic      one_o        // Pin 1 level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released line goes to the pull-up
  assign zero_o = zero_oe_n_i | zero_n_i;
  assign one_o  = one_oe_n_i | one_n_i;
endmodule : fpp_line_model

// file: bench/fpp_fault_propagate_props.sv
// Port checker for the fault pin propagation block
module fpp_props
  import fpp_pkg::*;
(
  input wire logic                      clk_i,               // Clock
  input wire logic                      reset_i,             // Reset
  input wire logic                      cmd_wr_i,            // Write
  input wire logic                      cmd_rd_i,            // Read
  input wire logic [7:0]                cmd_code_i,          // Code
  input wire logic                      nvm_load_i,          // Load
  input wire logic [FPP_PAGES-1:0]      multiphase_i,        // Multiphase
  input wire logic [FPP_PAGES-1:0]      run_req_i,           // Run
  input wire logic [FPP_PAGES-1:0]      decayed_i,           // Decayed
  input wire fpp_pkg::fpp_seq_t [FPP_PAGES-1:0] seq_i,       // Sequencing
  input wire logic [15:0]               cmd_rdata_o,         // Read word
  input wire logic                      cmd_hit_o,           // Hit
  input wire logic [FPP_PAGES-1:0]      restart_ok_o,        // Restart
  input wire logic                      fault_line_zero_n_o, // Pin 0 data
  input wire logic                      fault_line_zero_oe_n_o, // Pin 0 enable
  input wire logic                      fault_line_one_n_o,  // Pin 1 data
  input wire logic                      fault_line_one_oe_n_o   // Pin 1 enable
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  cmd_hit_a: assert property ((cmd_wr_i || cmd_rd_i) && cmd_code_i == FPP_CMD_PROPAGATE
    && !nvm_load_i |=> cmd_hit_o) else $error("missing hit");
  cmd_miss_a: assert property ((cmd_wr_i || cmd_rd_i) && cmd_code_i != FPP_CMD_PROPAGATE
    |=> !cmd_hit_o) else $error("hit on other code");
  rdata_hold_a: assert property (!cmd_rd_i |=> $stable(cmd_rdata_o))
    else $error("read word moved");
  reserved_zero_a: assert property ((cmd_rdata_o & ~(FPP_PROP_MASK | FPP_PROP_RESET)) == 16'h0000)
    else $error("reserved bit read as one");
  restart_hold_a: assert property (multiphase_i[0] && run_req_i[0] && seq_i[0].decay_wait
    && !decayed_i[0] |=> !restart_ok_o[0]) else $error("restart not withheld");
  restart_free_a: assert property (run_req_i[0] && !multiphase_i[0] |=> restart_ok_o[0])
    else $error("restart withheld");
  reset_state_a: assert property ($past(reset_i) |-> !cmd_hit_o && fault_line_zero_oe_n_o
    && fault_line_one_oe_n_o) else $error("bad state after reset");
  pin_data_a: assert property (!fault_line_zero_n_o && !fault_line_one_n_o)
    else $error("pin data not low");
endmodule : fpp_props

bind fpp_fault_propagate fpp_props props (.clk_i, .reset_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i,
  .nvm_load_i, .multiphase_i, .run_req_i, .decayed_i, .seq_i, .cmd_rdata_o, .cmd_hit_o,
  .restart_ok_o, .fault_line_zero_n_o, .fault_line_zero_oe_n_o, .fault_line_one_n_o,
  .fault_line_one_oe_n_o);

// file: bench/testbench.sv
// Self-checking bench for the fault pin propagation block
module testbench;
  import fpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int BITS [7] = '{1, 2, 4, 7, 8, 11, 13};
  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              page = 1'b0;
  logic [7:0]        code = FPP_CMD_PROPAGATE;
  logic [15:0]       wdata = 16'h0000;
  logic              nvm = 1'b0;
  logic [1:0][15:0]  nvw = '0;
  logic [1:0]        mph = 2'b00;
  logic [1:0]        run = 2'b00;
  logic [1:0]        dec = 2'b00;
  fpp_faults_t [1:0] flt = '0;
  fpp_faults_t [1:0] rsp = '0;
  fpp_seq_t [1:0]    sq = '0;
  logic [15:0]       rdata;
  logic              hit;
  logic [1:0]        rok;
  logic              d0, e0, d1, e1, line0, line1;
  int                n_errors = 0;
  int                comparisons = 0;

  fpp_fault_propagate #(.HOLD_CYC(HOLD)) dut (.clk_i, .reset_i, .cmd_wr_i(wr), .cmd_rd_i(rd),
    .cmd_code_i(code), .cmd_page_i(page), .cmd_wdata_i(wdata), .nvm_load_i(nvm),
    .nvm_word_i(nvw), .multiphase_i(mph), .run_req_i(run), .decayed_i(dec), .fault_i(flt),
    .respond_i(rsp), .seq_i(sq), .cmd_rdata_o(rdata), .cmd_hit_o(hit), .restart_ok_o(rok),
    .fault_line_zero_n_o(d0), .fault_line_zero_oe_n_o(e0), .fault_line_one_n_o(d1),
    .fault_line_one_oe_n_o(e1));
  fpp_line_model line (.zero_n_i(d0), .zero_oe_n_i(e0), .one_n_i(d1), .one_oe_n_i(e1),
    .zero_o(line0), .one_o(line1));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  task automatic wrw(input logic p, input logic [15:0] d);
    wr = 1'b1; page = p; wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wrw

  task automatic rdw(input logic p, input logic [7:0] c, input logic h, input logic [15:0] e);
    rd = 1'b1; page = p; code = c;
    tick(1);
    chk(16'(hit), 16'(h));
    chk(rdata, e);
    rd = 1'b0; code = FPP_CMD_PROPAGATE;
    tick(1);
  endtask : rdw

  // Pin levels as {line1, line0}, two cycles after the cause
  task automatic pins(input logic [1:0] e);
    tick(2);
    chk(16'({line1, line0}), 16'(e));
  endtask : pins

  initial
  begin
    tick(12);
    reset_i = 1'b0;
    rdw(1'b0, FPP_CMD_PROPAGATE, 1'b1, 16'h6993);
    rdw(1'b1, FPP_CMD_PROPAGATE, 1'b1, 16'h6993);
    wrw(1'b0, 16'hFFFF);
    rdw(1'b0, FPP_CMD_PROPAGATE, 1'b1, 16'hE997);
    rdw(1'b1, FPP_CMD_PROPAGATE, 1'b1, 16'h6993);
    rdw(1'b0, 8'hD3, 1'b0, 16'h6993);
    rsp = '1;
    for (int k = 0; k < 7; k++)
    begin
      wrw(1'b0, 16'(1 << BITS[k]));
      flt[0] = 7'(1 << k);
      pins(k == 2 ? 2'b00 : 2'b10);
      rsp[0] = '0;
      pins(2'b11);
      rsp[0] = '1;
      wrw(1'b0, 16'h0000);
      pins(2'b11);
    end
    flt[0] = '1;
    wrw(1'b0, 16'h1600);
    pins(2'b11);
    flt = '0;
    flt[1].ton_max = 1'b1;
    wrw(1'b1, 16'h2000);
    pins(2'b01);
    flt = '0;
    wrw(1'b0, 16'h4000);
    sq[0].short_cycle = 1'b1;
    tick(1);
    sq[0].short_cycle = 1'b0;
    pins(2'b10);
    sq[0].seq_off_done = 1'b1;
    tick(1);
    sq[0].seq_off_done = 1'b0;
    pins(2'b10);
    tick(HOLD - 4);
    pins(2'b10);
    tick(1);
    chk(16'({line1, line0}), 16'h0003);
    wrw(1'b0, 16'h8000);
    run = 2'b01;
    pins(2'b11);
    chk(16'(rok), 16'h0001);
    mph = 2'b01;
    sq[0].decay_wait = 1'b1;
    pins(2'b10);
    chk(16'(rok), 16'h0000);
    wrw(1'b0, 16'h0000);
    pins(2'b11);
    wrw(1'b0, 16'h8000);
    pins(2'b10);
    dec = 2'b01;
    pins(2'b11);
    chk(16'(rok), 16'h0001);
    nvw[0] = 16'hFFFF;
    nvw[1] = 16'h6993;
    nvm = 1'b1;
    tick(1);
    nvm = 1'b0;
    rdw(1'b0, FPP_CMD_PROPAGATE, 1'b1, 16'hE997);
    rdw(1'b1, FPP_CMD_PROPAGATE, 1'b1, 16'h6993);
    close_out();
  end
endmodule : testbench
